/* logic/osw_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "osw_map.vh"
module osw_port (
    input wire clk_sys_in,
    input wire rstn_in,
    input wire serial_select_pin_in,
    input wire serial_select_float_in,
    input wire sck_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_out,
    output reg pullup_en_out,
    output reg i2c_mode_out,
    input wire [79:0] meas_data_in,
    input wire disp_idle_in,
    output reg wr_valid_out,
    output reg wr_plane_out,
    output reg [4:0] wr_row_out,
    output reg [4:0] wr_col_out,
    output reg [8:0] wr_data_out,
    output reg wr_overrun_out
);
    // ==========================================================
    // Pin synchronisers
    wire [3:0] pins_s;
    wire sel_s = pins_s[0];
    wire flt_s = pins_s[1];
    wire sck_s = pins_s[2];
    wire sda_s = pins_s[3];

    osw_sync #(.W(4)) u_sync (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .async_in({sda_in, sck_in, serial_select_float_in,
            serial_select_pin_in}),
        .sync_out(pins_s)
    );

    reg sel_d_r;
    reg sck_d_r;
    reg sda_d_r;
    wire i2c_mode = flt_s;
    wire sck_rise = sck_s & ~sck_d_r;
    wire sck_fall = ~sck_s & sck_d_r;
    wire spi_start = ~i2c_mode & sel_d_r & ~sel_s;
    wire spi_act = ~i2c_mode & ~sel_s;
    wire i2c_start = i2c_mode & sck_s & sck_d_r & sda_d_r & ~sda_s;
    wire i2c_stop = i2c_mode & sck_s & sck_d_r & ~sda_d_r & sda_s;

    // ==========================================================
    // Serial engine
    localparam PH_IDLE = 3'd0;
    localparam PH_ADDR = 3'd1;
    localparam PH_WRITE = 3'd2;
    localparam PH_READ = 3'd3;
    localparam PH_IGNORE = 3'd4;

    reg [2:0] phase_r;
    reg [3:0] bitcnt_r;
    reg [7:0] rx_r;
    reg [7:0] tx_r;
    reg [3:0] meas_idx_r;
    reg nack_r;
    reg byte_rdy_r;
    reg [7:0] byte_r;
    reg txn_start_r;

    wire [7:0] rx_full = {rx_r[6:0], sda_s};
    wire [7:0] meas_byte = meas_data_in[meas_idx_r*8 +: 8];

    always @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            sel_d_r <= 1'b1;
            sck_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            phase_r <= PH_IDLE;
            bitcnt_r <= 4'h0;
            rx_r <= 8'h00;
            tx_r <= 8'h00;
            meas_idx_r <= 4'h0;
            nack_r <= 1'b0;
            byte_rdy_r <= 1'b0;
            byte_r <= 8'h00;
            txn_start_r <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
            pullup_en_out <= 1'b0;
            i2c_mode_out <= 1'b0;
        end
        else
        begin
            sel_d_r <= sel_s;
            sck_d_r <= sck_s;
            sda_d_r <= sda_s;
            pullup_en_out <= 1'b1;
            i2c_mode_out <= i2c_mode;
            sda_out <= 1'b0;
            byte_rdy_r <= 1'b0;
            txn_start_r <= 1'b0;
            if (spi_start || i2c_start)
            begin
                bitcnt_r <= 4'h0;
                txn_start_r <= 1'b1;
                phase_r <= i2c_start ? PH_ADDR : PH_IDLE;
                sda_oe_out <= 1'b0;
            end
            else if (i2c_stop || (!i2c_mode && sda_oe_out))
            begin
                phase_r <= PH_IDLE;
                sda_oe_out <= 1'b0;
            end
            else if (spi_act && sck_rise)
            begin
                rx_r <= rx_full;
                if (bitcnt_r == 4'h7)
                begin
                    bitcnt_r <= 4'h0;
                    byte_rdy_r <= 1'b1;
                    byte_r <= rx_full;
                end
                else
                    bitcnt_r <= bitcnt_r + 4'h1;
            end
            else if (i2c_mode && phase_r != PH_IDLE && sck_rise)
            begin
                if (bitcnt_r < 4'h8)
                begin
                    rx_r <= rx_full;
                    bitcnt_r <= bitcnt_r + 4'h1;
                    if (bitcnt_r == 4'h7 && phase_r == PH_WRITE)
                    begin
                        byte_rdy_r <= 1'b1;
                        byte_r <= rx_full;
                    end
                end
                else
                begin
                    bitcnt_r <= 4'h9;
                    if (phase_r == PH_READ)
                        nack_r <= sda_s;
                end
            end
            else if (i2c_mode && phase_r != PH_IDLE && sck_fall)
            begin
                if (bitcnt_r == 4'h8)
                begin
                    // Acknowledge our own addresses and every byte written to us
                    sda_oe_out <= (phase_r == PH_WRITE) ||
                        (phase_r == PH_ADDR &&
                        (rx_r == `OSW_I2C_ADDR_WR ||
                        rx_r == `OSW_I2C_ADDR_RD));
                end
                else if (bitcnt_r == 4'h9)
                begin
                    bitcnt_r <= 4'h0;
                    sda_oe_out <= 1'b0;
                    if (phase_r == PH_ADDR)
                    begin
                        if (rx_r == `OSW_I2C_ADDR_WR)
                            phase_r <= PH_WRITE;
                        else if (rx_r == `OSW_I2C_ADDR_RD)
                        begin
                            phase_r <= PH_READ;
                            meas_idx_r <= 4'h1;
                            tx_r <= meas_data_in[7:0];
                            sda_oe_out <= ~meas_data_in[7];
                            nack_r <= 1'b0;
                        end
                        else
                            phase_r <= PH_IGNORE;
                    end
                    else if (phase_r == PH_READ && !nack_r)
                    begin
                        // Filler after the last measurement byte
                        tx_r <= (meas_idx_r < `OSW_MEAS_BYTES) ?
                            meas_byte : `OSW_FILL_BYTE;
                        sda_oe_out <= (meas_idx_r < `OSW_MEAS_BYTES) ?
                            ~meas_byte[7] : 1'b0;
                        if (meas_idx_r < `OSW_MEAS_BYTES)
                            meas_idx_r <= meas_idx_r + 4'h1;
                    end
                end
                else if (phase_r == PH_READ && !nack_r)
                begin
                    tx_r <= {tx_r[6:0], 1'b0};
                    sda_oe_out <= ~tx_r[6];
                end
            end
        end
    end

    // ==========================================================
    // Byte parser
    localparam ST_ROW = 2'd0;
    localparam ST_RC = 2'd1;
    localparam ST_DATA = 2'd2;
    localparam ST_STREAM = 2'd3;

    reg [1:0] st_r;
    reg [4:0] row_r;
    reg [4:0] col_r;
    reg plane_r;
    reg font8_r;
    reg fmt_c_r;
    reg emit_r;
    reg [8:0] emit_data_r;
    reg [4:0] emit_row_r;
    reg [4:0] emit_col_r;
    reg emit_plane_r;
    reg pend_r;

    wire is_data = (st_r == ST_DATA) || (st_r == ST_STREAM);

    always @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            st_r <= ST_ROW;
            row_r <= `OSW_ROW_RST;
            col_r <= `OSW_COL_RST;
            plane_r <= 1'b0;
            font8_r <= 1'b0;
            fmt_c_r <= 1'b0;
            emit_r <= 1'b0;
            emit_data_r <= 9'h000;
            emit_row_r <= 5'h00;
            emit_col_r <= 5'h00;
            emit_plane_r <= 1'b0;
        end
        else
        begin
            emit_r <= 1'b0;
            if (txn_start_r)
            begin
                st_r <= ST_ROW;
                fmt_c_r <= 1'b0;
            end
            else if (byte_rdy_r && is_data)
            begin
                emit_r <= 1'b1;
                emit_row_r <= row_r;
                emit_col_r <= col_r;
                emit_plane_r <= plane_r;
                emit_data_r <= {font8_r & ~plane_r, byte_r};
                if (fmt_c_r)
                begin
                    st_r <= ST_STREAM;
                    if (col_r == `OSW_LAST_COL)
                    begin
                        col_r <= 5'h00;
                        row_r <= (row_r == `OSW_LAST_ROW) ?
                            5'h00 : row_r + 5'h01;
                    end
                    else
                        col_r <= col_r + 5'h01;
                end
                else
                    st_r <= ST_RC;
            end
            else if (byte_rdy_r && byte_r[`OSW_ROW_FLAG_BIT])
            begin
                row_r <= byte_r[4:0];
                plane_r <= byte_r[`OSW_PLANE_BIT];
                st_r <= ST_RC;
            end
            else if (byte_rdy_r && st_r == ST_RC)
            begin
                col_r <= byte_r[4:0];
                fmt_c_r <= byte_r[`OSW_FMT_BIT];
                if (!plane_r)
                    font8_r <= byte_r[`OSW_FONT8_BIT];
                st_r <= ST_DATA;
            end
        end
    end

    // ==========================================================
    // Write administrator: one write held until a display gap
    always @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            pend_r <= 1'b0;
            wr_valid_out <= 1'b0;
            wr_plane_out <= 1'b0;
            wr_row_out <= 5'h00;
            wr_col_out <= 5'h00;
            wr_data_out <= 9'h000;
            wr_overrun_out <= 1'b0;
        end
        else
        begin
            wr_valid_out <= 1'b0;
            if (emit_r)
            begin
                // A new byte replaces an uncommitted one
                pend_r <= 1'b1;
                wr_overrun_out <= wr_overrun_out | pend_r;
                wr_plane_out <= emit_plane_r;
                wr_row_out <= emit_row_r;
                wr_col_out <= emit_col_r;
                wr_data_out <= emit_data_r;
            end
            else if (pend_r && disp_idle_in)
            begin
                pend_r <= 1'b0;
                wr_valid_out <= 1'b1;
            end
        end
    end
endmodule // osw_port
`default_nettype wire

/* inc/osw_map.vh */
// Notes on behaviour
// - Driven select pin means SPI, floating means I2C
// - I2C address 7AH writes, 7BH reads measurements
// - Ten measurement bytes read-only, all else write-only
// - Read sends bytes 0..9, then filler until stop
// - Bit 7 set: row byte; clear: column byte
// - Column bit 6 selects streaming format
// - Row bit 5 selects attribute plane; bits 4:0 row
// - Character column bit 5 is font index bit 8
// - Format a: triplets; format b: column-data pairs
// - Streaming: every further byte is data, auto-advance
// - Streaming reuses latched font bit 8
// - No return from streaming within a packet
// - Host writes commit only in display idle slots
// - Floating select means I2C; pins weakly pulled up
`ifndef OSW_MAP_VH
`define OSW_MAP_VH
// ==========================================================
// I2C addressing
`define OSW_I2C_ADDR_WR 8'h7A
`define OSW_I2C_ADDR_RD 8'h7B
`define OSW_MEAS_BYTES 4'hA
`define OSW_FILL_BYTE 8'hFF
// ==========================================================
// Byte field positions
`define OSW_ROW_FLAG_BIT 7
`define OSW_FMT_BIT 6
`define OSW_PLANE_BIT 5
`define OSW_FONT8_BIT 5
// ==========================================================
// Reset values and wrap limits
`define OSW_ROW_RST 5'h00
`define OSW_COL_RST 5'h00
`define OSW_LAST_COL 5'h1F
`define OSW_LAST_ROW 5'h1F
`endif

/* logic/osw_sync.v */
`timescale 1ns/1ps
`default_nettype none
module osw_sync #(
    parameter W = 1
) (
    input wire clk_sys_in,
    input wire rstn_in,
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // Pull-ups make idle level high, so reset to ones
    always @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            meta_r <= {W{1'b1}};
            sync_r <= {W{1'b1}};
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // osw_sync
`default_nettype wire

/* tb/osw_port_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module osw_port_properties (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic serial_select_float_in,
    input wire logic disp_idle_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic pullup_en_out,
    input wire logic i2c_mode_out,
    input wire logic wr_valid_out,
    input wire logic wr_plane_out,
    input wire logic [8:0] wr_data_out,
    input wire logic wr_overrun_out
);
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);
    // ==========================================================
    // Write side
    wr_pulse_a: assert property (wr_valid_out |=> !wr_valid_out)
        else $error("write pulse longer than one cycle");
    idle_commit_a: assert property (wr_valid_out |-> $past(disp_idle_in))
        else $error("write committed outside idle slot");
    attr_bit8_a: assert property (
        wr_valid_out && wr_plane_out |-> !wr_data_out[8])
        else $error("attribute write carries font bit");
    overrun_hold_a: assert property (wr_overrun_out |=> wr_overrun_out)
        else $error("overrun flag dropped");
    // ==========================================================
    // Pins and bus type
    spi_quiet_a: assert property (!i2c_mode_out |-> !sda_oe_out)
        else $error("data pin driven in SPI mode");
    open_drain_a: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    pullup_on_a: assert property ($past(rstn_in) |-> pullup_en_out)
        else $error("pull-ups off after reset");
    // Sync chain takes a few cycles, so allow eight
    mode_follow_a: assert property (
        $stable(serial_select_float_in) [*8]
        |-> i2c_mode_out == serial_select_float_in)
        else $error("bus type does not follow select pin");
    cover property (wr_valid_out && wr_plane_out);
    cover property ($rose(sda_oe_out));
    cover property ($rose(wr_overrun_out));
endmodule // osw_port_properties
bind osw_port osw_port_properties u_props (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .serial_select_float_in(serial_select_float_in),
    .disp_idle_in(disp_idle_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .pullup_en_out(pullup_en_out),
    .i2c_mode_out(i2c_mode_out), .wr_valid_out(wr_valid_out),
    .wr_plane_out(wr_plane_out), .wr_data_out(wr_data_out),
    .wr_overrun_out(wr_overrun_out)
);
`default_nettype wire

/* tb/osw_host.sv */
`timescale 1ns/1ps
`default_nettype none
module osw_host (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic sel_out,
    output logic sck_out,
    output logic sda_low_out
);
    initial
    begin
        sel_out = 1'b1;
        sck_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task wait_q(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // ==========================================================
    // Bit level: data moves only mid low phase, so I2C never
    // sees it change beside an SCK edge
    task bit_io(input logic b, output logic r);
        sck_out = 1'b0;
        wait_q(2);
        sda_low_out = !b;
        wait_q(2);
        sck_out = 1'b1;
        wait_q(3);
        r = sda_in;
        wait_q(1);
    endtask
    task byte8(input logic [7:0] d, output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
    endtask
    task spi(input logic [7:0] d);
        logic [7:0] r;
        byte8(d, r);
    endtask
    // Low for the whole packet; line released when high
    task sel(input logic v);
        sda_low_out = 1'b0;
        sel_out = v;
        wait_q(4);
    endtask
    // ==========================================================
    // I2C framing
    task start;
        sda_low_out = 1'b1;
        wait_q(4);
    endtask
    task stop;
        sck_out = 1'b0;
        wait_q(2);
        sda_low_out = 1'b1;
        wait_q(2);
        sck_out = 1'b1;
        wait_q(4);
        sda_low_out = 1'b0;
        wait_q(4);
    endtask
    task i2c_tx(input logic [7:0] d, output logic ack);
        logic [7:0] r;
        byte8(d, r);
        bit_io(1'b1, ack);
    endtask
    task i2c_rx(input logic last, output logic [7:0] r);
        logic a;
        byte8(8'hFF, r);
        bit_io(last, a);
    endtask
endmodule // osw_host
`default_nettype wire

/* tb/osw_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin \
    failures++; $display("[FAIL] %0t got %h want %h", $time, a, b); \
    end end
module osw_port_tb;
    logic clk, rstn, flt, idle, a;
    logic [79:0] meas;
    logic [19:0] w = 0;
    logic [7:0] r;
    int failures = 0, n_tests = 0, wcnt = 0, en = 0, cyc = 0;
    wire sel, sck, sdal, oe, pu, mode, wv, wp, ov, sdo;
    wire [4:0] wr, wc;
    wire [8:0] wd;
    wire sda = !(sdal | oe);
    // Bit 8 opens a new packet; zero means no write expected
    logic [8:0] t_in [15] = '{9'h0A3, 9'h025, 9'h056, 9'h006,
        9'h078, 9'h081, 9'h07F, 9'h012, 9'h085, 9'h102, 9'h034,
        9'h09F, 9'h05F, 9'h055, 9'h066};
    logic [19:0] t_exp [15] = '{0, 0, 20'h8CA56, 0, 20'h8CC78, 0, 0,
        20'h07F12, 20'h08185, 0, 0, 0, 0, 20'h7FE55, 20'h00066};
    logic [39:0] q = 40'h8401110222;
    logic [31:0] p = 32'h7A9E03AB;
    osw_port uut (
        .clk_sys_in(clk), .rstn_in(rstn), .serial_select_pin_in(sel),
        .serial_select_float_in(flt), .sck_in(sck), .sda_in(sda),
        .sda_out(sdo), .sda_oe_out(oe), .pullup_en_out(pu),
        .i2c_mode_out(mode), .meas_data_in(meas), .disp_idle_in(idle),
        .wr_valid_out(wv), .wr_plane_out(wp), .wr_row_out(wr),
        .wr_col_out(wc), .wr_data_out(wd), .wr_overrun_out(ov)
    );
    osw_host host (.clk_in(clk), .sda_in(sda), .sel_out(sel),
        .sck_out(sck), .sda_low_out(sdal));
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        if (wv === 1'b1)
        begin
            w <= {wp, wr, wc, wd};
            wcnt <= wcnt + 1;
        end
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            conclude;
        end
    end
    task conclude;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================================
    // Sequence
    initial
    begin
        clk = 1'b0;
        rstn = 1'b0;
        flt = 1'b0;
        idle = 1'b1;
        meas = 80'hC9C8C7C6C5C4C3C2C1C0;
        repeat (5) @(negedge clk);
        rstn = 1;
        host.wait_q(8);
        `CHK(pu, 1'b1)
        `CHK(sdo, 1'b0)
        `CHK(mode, 1'b0)
        host.sel(1'b0);
        for (int i = 0; i < 15; i++)
        begin
            if (t_in[i][8])
            begin
                host.sel(1'b1);
                host.sel(1'b0);
            end
            host.spi(t_in[i][7:0]);
            host.wait_q(6);
            if (t_exp[i] != 0)
            begin
                en++;
                `CHK(w, t_exp[i])
            end
            `CHK(wcnt, en)
        end
        // Two writes with no idle slot: second replaces first
        host.sel(1'b1);
        host.sel(1'b0);
        idle = 1'b0;
        for (int i = 4; i >= 0; i--)
            host.spi(q[8*i +: 8]);
        host.wait_q(6);
        `CHK(wcnt, en)
        `CHK(ov, 1'b1)
        idle = 1'b1;
        host.wait_q(4);
        `CHK(wcnt, en + 1)
        `CHK(w, 20'h10422)
        host.sel(1'b1);
        // Overrun is sticky; only a reset clears it
        rstn = 1'b0;
        host.wait_q(5);
        `CHK(ov, 1'b0)
        rstn = 1'b1;
        flt = 1'b1;
        host.wait_q(10);
        `CHK(mode, 1'b1)
        `CHK(pu, 1'b1)
        host.start;
        host.i2c_tx(8'h70, a);
        `CHK(a, 1'b1)
        host.stop;
        host.start;
        for (int i = 3; i >= 0; i--)
        begin
            host.i2c_tx(p[8*i +: 8], a);
            `CHK(a, 1'b0)
        end
        host.stop;
        `CHK(w, 20'h786AB)
        host.start;
        host.i2c_tx(8'h7B, a);
        `CHK(a, 1'b0)
        for (int k = 0; k < 11; k++)
        begin
            host.i2c_rx(k == 10, r);
            `CHK(r, (k < 10) ? 8'hC0 + k[7:0] : 8'hFF)
        end
        host.stop;
        // Fresh measurements must show up on the next read
        meas = 80'h0123456789ABCDEF5A3C;
        host.start;
        host.i2c_tx(8'h7B, a);
        `CHK(a, 1'b0)
        host.i2c_rx(1'b0, r);
        `CHK(r, 8'h3C)
        host.i2c_rx(1'b1, r);
        `CHK(r, 8'h5A)
        host.stop;
        conclude;
    end
endmodule // osw_port_tb
`default_nettype wire
